// ### design/wpr_pkg.sv
// Shared constants and types of the wireless power receiver link
package wpr_pkg;
  localparam int CLK_HZ     = 100_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int FAST_MS    = 30;
  localparam int SLOW_MS    = 250;
  localparam int SETTLE_MS  = 150;
  localparam int FAST_CYC_DEF   = FAST_MS * CYC_PER_MS;
  localparam int SLOW_CYC_DEF   = SLOW_MS * CYC_PER_MS;
  localparam int SETTLE_CYC_DEF = SETTLE_MS * CYC_PER_MS;
  localparam int TMR_W = 25;

  typedef enum logic [3:0] {
    PKT_NONE     = 4'h0,
    PKT_STRENGTH = 4'h1,
    PKT_CONFIG   = 4'h2,
    PKT_IDENT    = 4'h3,
    PKT_CTRL_ERR = 4'h4,
    PKT_END_PWR  = 4'h5,
    PKT_PMA_RESP = 4'h8,
    PKT_PMA_INC  = 4'h9,
    PKT_PMA_DEC  = 4'ha,
    PKT_PMA_NOCH = 4'hb,
    PKT_PMA_EOC  = 4'hc
  } wpr_pkt_type;

  // End-power-transfer reason codes
  localparam logic [7:0] EPT_UNKNOWN  = 8'h00;
  localparam logic [7:0] EPT_CHARGED  = 8'h01;
  localparam logic [7:0] EPT_FAULT    = 8'h02;
  localparam logic [7:0] EPT_OVERTEMP = 8'h03;
  localparam logic [7:0] EPT_OVERVOLT = 8'h04;

  // Rectifier codes in 0.1 V steps
  localparam logic [7:0] RECT_STARTUP = 8'h50;
  localparam logic [7:0] RAMP_TARGET  = 8'h52;
  localparam logic [7:0] TGT_BASE     = 8'h32;
  localparam int         TGT_SHIFT    = 2;
  localparam logic [7:0] CE_WIN       = 8'h02;
  localparam logic [6:0] CE_START_MAX = 7'h40;
  localparam logic [7:0] CE_POS_MAX   = 8'h7f;
  localparam logic [7:0] CE_NEG_MAX   = 8'h80;
  localparam logic [7:0] STRENGTH_VAL = 8'hff;
  localparam logic [7:0] CONFIG_VAL   = 8'h05;
  localparam logic [7:0] IDENT_VAL    = 8'h5a; // Arbitrary value

  // Synchronised comparator bus positions
  localparam int S_PMEM = 0;
  localparam int S_HOT  = 1;
  localparam int S_CLO  = 2;
  localparam int S_CHG  = 3;
  localparam int S_ADP  = 4;
  localparam int S_FLT  = 5;
  localparam int S_OVP  = 6;
  localparam int S_SRG  = 7;
  localparam int S_UH   = 8;
  localparam int S_UL   = 9;
  localparam int S_LH   = 10;
  localparam int S_LL   = 11;
  localparam int S_PMA  = 12;
  localparam int S_W    = 13;

  // Transmitter controller registers (byte addresses)
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int         CTRL_EN    = 0;
  localparam logic       CTRL_EN_RST = 1'b0;
endpackage : wpr_pkg

// ### design/wpr_link_if.sv
// Packet link between receiver and transmitter controller
`timescale 1ns/100ps
interface wpr_link_if;
  logic                 power_on;
  logic                 grant;
  logic                 pkt_ready;
  logic                 pkt_valid;
  wpr_pkg::wpr_pkt_type pkt_type;
  logic [7:0]           pkt_data;

  modport rx (
    input  power_on,
    input  grant,
    input  pkt_ready,
    output pkt_valid,
    output pkt_type,
    output pkt_data
  );
  modport tx (
    output power_on,
    output grant,
    output pkt_ready,
    input  pkt_valid,
    input  pkt_type,
    input  pkt_data
  );
endinterface : wpr_link_if

// ### design/wpr_sync.sv
// Two-flop synchroniser bank
`timescale 1ns/100ps
module wpr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : wpr_sync

// ### design/wpr_rx_end.sv
// Receiver end: startup handshake, control loop and end of transfer
`timescale 1ns/100ps
module wpr_rx_end #(
  parameter int FAST_CYC   = wpr_pkg::FAST_CYC_DEF,
  parameter int SLOW_CYC   = wpr_pkg::SLOW_CYC_DEF,
  parameter int SETTLE_CYC = wpr_pkg::SETTLE_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  wpr_link_if.rx          link,
  input  wire logic       mode_pma,
  input  wire logic       ping_mem_hi,
  input  wire logic       therm_hot,
  input  wire logic       ctrl_low,
  input  wire logic       charge_done,
  input  wire logic       adapter_present,
  input  wire logic       internal_fault,
  input  wire logic       rect_ovp,
  input  wire logic       input_surge,
  input  wire logic       above_upper_high,
  input  wire logic       above_upper_low,
  input  wire logic       above_lower_high,
  input  wire logic       above_lower_low,
  input  wire logic [7:0] rect_code,
  input  wire logic [6:0] iout_pct,
  output logic            pad_detect_n_o,
  output logic            pad_detect_n_oe,
  output logic            ldo_en,
  output logic            contract_ok,
  output logic            not_converged,
  output logic [7:0]      end_code
);
  import wpr_pkg::*;

  typedef enum logic [3:0] {
    ST_OFF   = 4'b0000,
    ST_SS    = 4'b0001,
    ST_CFG   = 4'b0011,
    ST_ID    = 4'b0010,
    ST_WAITG = 4'b0110,
    ST_RAMP  = 4'b0111,
    ST_ACT   = 4'b0101,
    ST_END   = 4'b0100,
    ST_STOP  = 4'b1100,
    ST_PRESP = 4'b1101,
    ST_PRUN  = 4'b1111
  } wpr_rx_state_type;

  wpr_rx_state_type state_ff;
  wpr_rx_state_type nxt_state;
  logic [S_W-1:0]   raw_in;
  logic [S_W-1:0]   syn;
  logic             pma;
  logic             end_req;
  logic [7:0]       end_why;
  logic [7:0]       nxt_end_code;
  logic             issue;
  wpr_pkt_type      iss_type;
  logic [7:0]       iss_data;
  logic             accepted;
  logic             periodic;
  logic             timer_run;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] tmr_last;
  logic             tick;
  logic             tick_pend_ff;
  logic             ovp_d_ff;
  logic [6:0]       ce_cnt_ff;
  logic [7:0]       tgt_dyn;
  logic [7:0]       tgt_sel;
  logic [7:0]       tgt_ff;
  logic [8:0]       diff;
  logic [7:0]       ce_val;
  logic [TMR_W-1:0] settle_ff;
  logic             out_en_ff;
  wpr_pkt_type      dir_ff;
  wpr_pkt_type      nxt_dir;
  wpr_pkt_type      pma_sig;

  assign raw_in = {mode_pma, above_lower_low, above_lower_high, above_upper_low,
                   above_upper_high, input_surge, rect_ovp, internal_fault,
                   adapter_present, charge_done, ctrl_low, therm_hot, ping_mem_hi};

  wpr_sync #(.W(S_W)) wpr_sync_inst (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (raw_in),
    .q     (syn)
  );

  assign pma = syn[S_PMA];
  assign pad_detect_n_o = 1'b0;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pad_detect_n_oe <= 1'b0;
    else
      pad_detect_n_oe <= ~pma & syn[S_PMEM];
  end

  // End condition and its reason, hottest first
  always_comb
  begin
    end_req = 1'b1;
    end_why = EPT_UNKNOWN;
    if (syn[S_HOT] | syn[S_CLO])
      end_why = EPT_OVERTEMP;
    else if (syn[S_FLT])
      end_why = EPT_FAULT;
    else if (syn[S_ADP])
      end_why = EPT_UNKNOWN;
    else if (syn[S_CHG])
      end_why = EPT_CHARGED;
    else
      end_req = 1'b0;
  end

  assign tgt_dyn = TGT_BASE + 8'(iout_pct >> TGT_SHIFT);
  assign tgt_sel = (state_ff == ST_RAMP) ? RAMP_TARGET : tgt_dyn;
  assign diff    = {1'b0, tgt_sel} - {1'b0, rect_code};
  assign ce_val  = (diff[8] != diff[7]) ? (diff[8] ? CE_NEG_MAX : CE_POS_MAX) : diff[7:0];

  // PMA zone decision with entry direction memory
  always_comb
  begin
    nxt_dir = dir_ff;
    pma_sig = PKT_PMA_NOCH;
    if (syn[S_UH])
    begin
      nxt_dir = PKT_PMA_INC;
      pma_sig = PKT_PMA_INC;
    end
    else if (!syn[S_LL])
    begin
      nxt_dir = PKT_PMA_DEC;
      pma_sig = PKT_PMA_DEC;
    end
    else if (syn[S_LH] && !syn[S_UL])
      nxt_dir = PKT_PMA_NOCH;
    else if (syn[S_UL])
      pma_sig = (dir_ff == PKT_PMA_INC) ? PKT_PMA_INC : PKT_PMA_NOCH;
    else
      pma_sig = (dir_ff == PKT_PMA_DEC) ? PKT_PMA_DEC : PKT_PMA_NOCH;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      dir_ff <= PKT_PMA_NOCH;
    else if (state_ff != ST_PRUN)
      dir_ff <= PKT_PMA_NOCH;
    else
      dir_ff <= nxt_dir;
  end

  // Packet cadence timer
  assign timer_run = (state_ff == ST_RAMP) | (state_ff == ST_ACT) | (state_ff == ST_PRUN);
  assign tmr_last  = ((state_ff == ST_RAMP) | syn[S_SRG]) ?
                     TMR_W'(FAST_CYC - 1) : TMR_W'(SLOW_CYC - 1);
  assign tick      = timer_run & (tmr_ff >= tmr_last);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tmr_ff <= '0;
    else if (!timer_run || tick)
      tmr_ff <= '0;
    else
      tmr_ff <= tmr_ff + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ovp_d_ff <= 1'b0;
    else
      ovp_d_ff <= syn[S_OVP];
  end

  // Pending periodic packet; a new tick wins over the clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      tick_pend_ff <= 1'b0;
    else if (!timer_run)
      tick_pend_ff <= 1'b0;
    else if (tick || (syn[S_OVP] && !ovp_d_ff))
      tick_pend_ff <= 1'b1;
    else if (issue && periodic)
      tick_pend_ff <= 1'b0;
  end

  assign accepted = link.pkt_valid & link.pkt_ready;
  assign periodic = timer_run & tick_pend_ff & ~link.pkt_valid;

  // Sequencer
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_end_code = end_code;
    issue        = 1'b0;
    iss_type     = PKT_NONE;
    iss_data     = '0;
    unique case (state_ff)
      ST_OFF:
        if (link.power_on)
        begin
          if (end_req)
          begin
            nxt_state    = ST_END;
            nxt_end_code = end_why;
          end
          else
            nxt_state = pma ? ST_PRESP : ST_SS;
        end
      ST_SS:
      begin
        issue    = ~link.pkt_valid;
        iss_type = PKT_STRENGTH;
        iss_data = STRENGTH_VAL;
        if (accepted)
          nxt_state = ST_CFG;
      end
      ST_CFG:
      begin
        issue    = ~link.pkt_valid;
        iss_type = PKT_CONFIG;
        iss_data = CONFIG_VAL;
        if (accepted)
          nxt_state = ST_ID;
      end
      ST_ID:
      begin
        issue    = ~link.pkt_valid;
        iss_type = PKT_IDENT;
        iss_data = IDENT_VAL;
        if (accepted)
          nxt_state = ST_WAITG;
      end
      ST_WAITG:
        if (link.grant)
          nxt_state = ST_RAMP;
      ST_RAMP, ST_ACT:
      begin
        issue    = periodic;
        iss_type = PKT_CTRL_ERR;
        iss_data = ce_val;
        if (end_req)
        begin
          nxt_state    = ST_END;
          nxt_end_code = end_why;
        end
        else if (state_ff == ST_RAMP && rect_code >= RECT_STARTUP)
          nxt_state = ST_ACT;
        else if (state_ff == ST_RAMP && ce_cnt_ff == CE_START_MAX)
        begin
          nxt_state    = ST_END;
          nxt_end_code = EPT_OVERVOLT;
        end
      end
      ST_PRESP:
      begin
        issue    = ~link.pkt_valid;
        iss_type = PKT_PMA_RESP;
        if (accepted)
          nxt_state = ST_PRUN;
      end
      ST_PRUN:
      begin
        issue    = periodic;
        iss_type = pma_sig;
        if (end_req)
        begin
          nxt_state    = ST_END;
          nxt_end_code = end_why;
        end
      end
      ST_END:
      begin
        issue    = ~link.pkt_valid;
        iss_type = pma ? PKT_PMA_EOC : PKT_END_PWR;
        iss_data = end_code;
        if (accepted)
          nxt_state = ST_STOP;
      end
      ST_STOP:
        nxt_state = ST_STOP;
      default:
        nxt_state = ST_OFF;
    endcase
    if (!link.power_on)
      nxt_state = ST_OFF;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_OFF;
      end_code <= EPT_UNKNOWN;
    end
    else
    begin
      state_ff <= nxt_state;
      end_code <= nxt_end_code;
    end
  end

  // Outgoing packet register, held until accepted
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link.pkt_valid <= 1'b0;
      link.pkt_type  <= PKT_NONE;
      link.pkt_data  <= '0;
    end
    else if (!link.power_on)
      link.pkt_valid <= 1'b0;
    else if (issue)
    begin
      link.pkt_valid <= 1'b1;
      link.pkt_type  <= iss_type;
      link.pkt_data  <= iss_data;
    end
    else if (link.pkt_ready)
      link.pkt_valid <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ce_cnt_ff <= '0;
    else if (state_ff != ST_RAMP)
      ce_cnt_ff <= '0;
    else if (accepted && link.pkt_type == PKT_CTRL_ERR)
      ce_cnt_ff <= ce_cnt_ff + 1'b1;
  end

  // Settling window restarts whenever the target moves
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tgt_ff        <= '0;
      settle_ff     <= '0;
      not_converged <= 1'b0;
    end
    else
    begin
      tgt_ff <= tgt_dyn;
      if (state_ff != ST_ACT || tgt_ff != tgt_dyn)
        settle_ff <= '0;
      else if (settle_ff < TMR_W'(SETTLE_CYC))
        settle_ff <= settle_ff + 1'b1;
      not_converged <= (state_ff == ST_ACT) && (settle_ff >= TMR_W'(SETTLE_CYC)) &&
                       (($signed(ce_val) > $signed(CE_WIN)) ||
                        ($signed(ce_val) < -$signed(CE_WIN)));
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_en_ff   <= 1'b0;
      ldo_en      <= 1'b0;
      contract_ok <= 1'b0;
    end
    else
    begin
      out_en_ff   <= (nxt_state == ST_ACT) | (nxt_state == ST_PRUN);
      ldo_en      <= out_en_ff & ~syn[S_OVP];
      contract_ok <= (state_ff == ST_RAMP) | (state_ff == ST_ACT);
    end
  end
endmodule : wpr_rx_end

// ### design/wpr_tx_end.sv
// Transmitter controller end with Avalon-MM register access
`timescale 1ns/100ps
module wpr_tx_end (
  input  wire logic        clk,
  input  wire logic        rst_b,
  wpr_link_if.tx           link,
  input  wire logic        object_detected,
  input  wire logic        tx_pma,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest
);
  import wpr_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_WAIT = 3'b001,
    H_CFG  = 3'b011,
    H_ID   = 3'b010,
    H_XFER = 3'b110,
    H_DOWN = 3'b100
  } wpr_tx_state_type;

  wpr_tx_state_type state_ff;
  wpr_tx_state_type nxt_state;
  logic             en_ff;
  logic             ack_ff;
  logic             got;
  wpr_pkt_type      last_type_ff;
  logic [7:0]       last_data_ff;

  assign got = link.pkt_valid & link.pkt_ready;
  assign link.pkt_ready = link.power_on;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      H_IDLE:
        if (en_ff && object_detected)
          nxt_state = H_WAIT;
      H_WAIT:
        if (got)
        begin
          if (tx_pma)
            nxt_state = (link.pkt_type == PKT_PMA_RESP) ? H_XFER : H_DOWN;
          else
            nxt_state = (link.pkt_type == PKT_STRENGTH) ? H_CFG : H_DOWN;
        end
      H_CFG:
        if (got)
          nxt_state = (link.pkt_type == PKT_CONFIG) ? H_ID : H_DOWN;
      H_ID:
        if (got)
          nxt_state = (link.pkt_type == PKT_IDENT) ? H_XFER : H_DOWN;
      H_XFER:
        if (got && (link.pkt_type == PKT_END_PWR || link.pkt_type == PKT_PMA_EOC))
          nxt_state = H_DOWN;
      H_DOWN:
        if (!object_detected)
          nxt_state = H_IDLE;
      default:
        nxt_state = H_IDLE;
    endcase
    if (!en_ff)
      nxt_state = H_IDLE;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff      <= H_IDLE;
      link.power_on <= 1'b0;
      link.grant    <= 1'b0;
    end
    else
    begin
      state_ff      <= nxt_state;
      link.power_on <= (nxt_state != H_IDLE) && (nxt_state != H_DOWN);
      link.grant    <= (nxt_state == H_XFER) && !tx_pma;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_type_ff <= PKT_NONE;
      last_data_ff <= '0;
    end
    else if (got)
    begin
      last_type_ff <= link.pkt_type;
      last_data_ff <= link.pkt_data;
    end
  end

  // One wait state on every access
  assign waitrequest = (read | write) & ~ack_ff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_ff   <= 1'b0;
      en_ff    <= CTRL_EN_RST;
      readdata <= '0;
    end
    else
    begin
      ack_ff <= (read | write) & ~ack_ff;
      if (write && ack_ff && address == REG_CTRL && byteenable[0])
        en_ff <= writedata[CTRL_EN];
      if (read && !ack_ff)
      begin
        unique case (address)
          REG_CTRL:
            readdata <= {31'h0000_0000, en_ff};
          REG_STATUS:
            readdata <= {16'h0000, last_data_ff, last_type_ff,
                         1'b0, state_ff == H_XFER, link.grant, link.power_on};
          default:
            readdata <= '0;
        endcase
      end
    end
  end
endmodule : wpr_tx_end

// ### tb/wpr_properties.sv
// Link protocol assertions between the receiver and transmitter ends
`timescale 1ns/100ps
module wpr_properties (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 power_on,
  input wire logic                 grant,
  input wire logic                 pkt_ready,
  input wire logic                 pkt_valid,
  input wire wpr_pkg::wpr_pkt_type pkt_type,
  input wire logic [7:0]           pkt_data
);
  import wpr_pkg::*;
  logic tk;
  assign tk = pkt_valid && pkt_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RESP_KEEPS_POWER: assert property (tk && pkt_type == PKT_PMA_RESP |=> power_on)
    else $error("power dropped after response");
  AST_TAKE_DROPS: assert property (tk |=> !pkt_valid)
    else $error("valid held after take");
  AST_FIRST_PKT: assert property ($rose(power_on) |-> ##[1:6] (pkt_valid &&
    pkt_type inside {PKT_STRENGTH, PKT_END_PWR, PKT_PMA_RESP, PKT_PMA_EOC}))
    else $error("wrong first packet");
  AST_CONFIG_NEXT: assert property (tk && pkt_type == PKT_STRENGTH |->
    pkt_data == STRENGTH_VAL ##[2:4] (pkt_valid && pkt_type == PKT_CONFIG))
    else $error("config not after strength");
  AST_IDENT_NEXT: assert property (tk && pkt_type == PKT_CONFIG |->
    pkt_data == CONFIG_VAL ##[2:4] (pkt_valid && pkt_type == PKT_IDENT))
    else $error("ident not after config");
  AST_GRANT_IDENT: assert property (tk && pkt_type == PKT_IDENT |->
    pkt_data == IDENT_VAL ##1 grant)
    else $error("grant missing after ident");
  AST_CE_GRANTED: assert property (pkt_valid && pkt_type == PKT_CTRL_ERR |-> grant)
    else $error("control error without grant");
  AST_END_REASON: assert property (pkt_valid && pkt_type == PKT_END_PWR |->
    pkt_data <= EPT_OVERVOLT)
    else $error("end reason out of range");
  AST_END_OFF: assert property (tk && pkt_type inside {PKT_END_PWR, PKT_PMA_EOC} |->
    ##[1:3] !power_on)
    else $error("power kept after end");
  AST_OFF_NO_VALID: assert property (!power_on [*2] |=> !pkt_valid)
    else $error("valid without power");
  COV_STRENGTH: cover property (tk && pkt_type == PKT_STRENGTH);
  COV_END: cover property (tk && pkt_type == PKT_END_PWR);
  COV_PMA_DEC: cover property (tk && pkt_type == PKT_PMA_DEC);
  COV_GRANT: cover property ($rose(grant));
endmodule : wpr_properties

// ### tb/wireless_rx_power_control_tb.sv
// Self-checking bench joining the receiver and transmitter ends
`timescale 1ns/100ps
module wireless_rx_power_control_tb;
  import wpr_pkg::*;
  typedef struct packed {wpr_pkt_type t; logic [7:0] d; logic d_on;} wpr_exp_type;
  localparam int FC = 20;
  localparam int SC = 60;
  logic        clk = 0, rst_b = 0, obj = 0, tx_pma = 0, mode_pma = 0, pmem = 0;
  logic        ovp = 0, surge = 0, read = 0, write = 0;
  logic [4:0]  cond = '0;
  logic [3:0]  thr = '0, address = '0, be = '0;
  logic [7:0]  rect = '0, r, end_code;
  logic [6:0]  iout = '0, iv;
  logic [31:0] wdata = '0, rdata, q;
  logic        waitreq, pd_o, pd_oe, ldo_en, c_ok, n_conv;
  int          n_mismatch = 0, samples_checked = 0, seed = 46, cyc = 0, ce_seen = 0, t0, t1;
  wpr_exp_type exp_q[$];
  wpr_exp_type e;
  logic [7:0]  codes [5] = '{EPT_CHARGED, EPT_UNKNOWN, EPT_FAULT, EPT_OVERTEMP, EPT_OVERTEMP};
  logic [3:0]  tv [7] = '{4'h7, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h7};
  wpr_pkt_type pe [7] = '{PKT_PMA_INC, PKT_PMA_NOCH, PKT_PMA_NOCH, PKT_PMA_DEC, PKT_PMA_DEC,
                          PKT_PMA_NOCH, PKT_PMA_NOCH};
  wpr_link_if link ();
  wpr_rx_end #(.FAST_CYC(FC), .SLOW_CYC(SC), .SETTLE_CYC(30)) wpr_rx_end_inst (
    .clk(clk), .rst_b(rst_b), .link(link), .mode_pma(mode_pma), .ping_mem_hi(pmem),
    .therm_hot(cond[4]), .ctrl_low(cond[3]), .internal_fault(cond[2]),
    .adapter_present(cond[1]), .charge_done(cond[0]), .rect_ovp(ovp), .input_surge(surge),
    .above_upper_high(thr[3]), .above_upper_low(thr[2]), .above_lower_high(thr[1]),
    .above_lower_low(thr[0]), .rect_code(rect), .iout_pct(iout), .pad_detect_n_o(pd_o),
    .pad_detect_n_oe(pd_oe), .ldo_en(ldo_en), .contract_ok(c_ok), .not_converged(n_conv),
    .end_code(end_code));
  wpr_tx_end wpr_tx_end_inst (
    .clk(clk), .rst_b(rst_b), .link(link), .object_detected(obj), .tx_pma(tx_pma),
    .address(address), .read(read), .write(write), .writedata(wdata), .byteenable(be),
    .readdata(rdata), .waitrequest(waitreq));
  wpr_properties wpr_properties_inst (
    .clk(clk), .rst_b(rst_b), .power_on(link.power_on), .grant(link.grant),
    .pkt_ready(link.pkt_ready), .pkt_valid(link.pkt_valid), .pkt_type(link.pkt_type),
    .pkt_data(link.pkt_data));

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task check(input string nm, input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, expv, seen);
    end
  endtask : check

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task av(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    read <= rd;
    write <= !rd;
    address <= a;
    wdata <= d;
    be <= b;
    // Waitrequest and read data are taken at the same rising edge
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0);
    q = rdata;
    read <= 0;
    write <= 0;
    check("bus wait states", n, 2);
  endtask : av

  // Wait for a packet of one type to be taken, stamp its cycle
  task wt(input wpr_pkt_type t, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(link.pkt_valid === 1'b1 && link.pkt_ready === 1'b1 && link.pkt_type === t)
           && n < lim);
    if (n >= lim) check("packet wait", 0, 1);
    t0 = t1;
    t1 = cyc;
    @(negedge clk);
  endtask : wt

  task push(input wpr_pkt_type t, input logic [7:0] d, input logic on);
    exp_q.push_back('{t, d, on});
  endtask : push

  task gap(input string nm);
    @(posedge clk);
    obj <= 0;
    cond <= '0;
    repeat (6) @(posedge clk);
    $display("test %s finished", nm);
  endtask : gap

  // Scoreboard: control errors pass unchecked unless one is expected next
  always @(posedge clk)
  begin
    if (link.pkt_valid && link.pkt_ready && link.pkt_type == PKT_CTRL_ERR)
      ce_seen <= ce_seen + 1;
    if (link.pkt_valid && link.pkt_ready && exp_q.size() > 0 &&
        (link.pkt_type != PKT_CTRL_ERR || exp_q[0].t == PKT_CTRL_ERR))
    begin
      e = exp_q.pop_front();
      check("packet type", link.pkt_type, e.t);
      if (e.d_on) check("packet data", link.pkt_data, e.d);
    end
  end

  initial
  begin
    #300_000;
    check("watchdog", 0, 1);
    stop_test();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    av(1, REG_CTRL, 0, 4'hf);
    check("ctrl reset", q, 32'h0000_0000);
    av(1, 4'h8, 0, 4'hf);
    check("unmapped read", q, 32'h0000_0000);
    av(0, 4'hc, 32'hffff_ffff, 4'hf);
    av(0, REG_CTRL, 32'h0000_0001, 4'he);
    av(1, REG_CTRL, 0, 4'hf);
    check("ctrl masked write", q, 32'h0000_0000);
    av(0, REG_CTRL, 32'h0000_0001, 4'h1);
    av(1, REG_CTRL, 0, 4'hf);
    check("ctrl enable", q, 32'h0000_0001);
    $display("test registers finished");
    // Weak coupling: rectifier never reaches startup level
    r = 8'($random(seed)) & 8'h3f;
    push(PKT_STRENGTH, STRENGTH_VAL, 1);
    push(PKT_CONFIG, CONFIG_VAL, 1);
    push(PKT_IDENT, IDENT_VAL, 1);
    push(PKT_CTRL_ERR, RAMP_TARGET - r, 1);
    push(PKT_END_PWR, EPT_OVERVOLT, 1);
    ce_seen = 0;
    @(posedge clk);
    rect <= r;
    obj <= 1;
    wt(PKT_IDENT, 20);
    av(1, REG_STATUS, 0, 4'hf);
    check("status grant", q[1:0], 2'b11);
    repeat (2) @(negedge clk);
    check("contract", c_ok, 1'b1);
    wt(PKT_END_PWR, 64 * FC + 200);
    check("ramp packets", ce_seen, 64);
    check("ldo in ramp", ldo_en, 1'b0);
    gap("ramp timeout");
    // Ramp to active, periods, overvoltage, pad detect, hot end
    r = 8'($random(seed)) & 8'h3f;
    iv = 7'($random(seed));
    push(PKT_STRENGTH, STRENGTH_VAL, 1);
    push(PKT_CONFIG, CONFIG_VAL, 1);
    push(PKT_IDENT, IDENT_VAL, 1);
    push(PKT_CTRL_ERR, RAMP_TARGET - r, 1);
    @(posedge clk);
    rect <= r;
    iout <= iv;
    obj <= 1;
    wt(PKT_CTRL_ERR, 40);
    push(PKT_CTRL_ERR, TGT_BASE + 8'(iv >> TGT_SHIFT) - 8'h55, 1);
    @(posedge clk);
    rect <= 8'h55;
    wt(PKT_CTRL_ERR, SC + 30);
    repeat (3) @(negedge clk);
    check("ldo active", ldo_en, 1'b1);
    check("not converged", n_conv, 1'b1);
    @(posedge clk);
    iout <= iv ^ 7'h04;
    repeat (3) @(negedge clk);
    check("settle restart", n_conv, 1'b0);
    wt(PKT_CTRL_ERR, SC + 30);
    check("slow period", (t1 - t0) inside {[SC - 2:SC + 2]}, 1'b1);
    @(posedge clk);
    surge <= 1;
    wt(PKT_CTRL_ERR, SC + 30);
    wt(PKT_CTRL_ERR, FC + 10);
    check("fast period", (t1 - t0) inside {[FC - 2:FC + 2]}, 1'b1);
    @(posedge clk);
    surge <= 0;
    ovp <= 1;
    wt(PKT_CTRL_ERR, 8);
    check("ldo overvoltage", ldo_en, 1'b0);
    @(posedge clk);
    ovp <= 0;
    pmem <= 1;
    repeat (4) @(negedge clk);
    check("pad pull", {pd_oe, pd_o}, 2'b10);
    push(PKT_END_PWR, EPT_OVERTEMP, 1);
    @(posedge clk);
    cond <= 5'h10;
    wt(PKT_END_PWR, 20);
    repeat (2) @(negedge clk);
    check("end code", end_code, EPT_OVERTEMP);
    gap("wpc active");
    // A condition present at power-up ends at once with its reason
    for (int i = 0; i < 5; i++)
    begin
      push(PKT_END_PWR, codes[i], 1);
      cond <= 5'(1 << i);
      repeat (4) @(posedge clk);
      obj <= 1;
      wt(PKT_END_PWR, 30);
      gap("startup end");
    end
    // PMA: response, then stepping through the threshold zones
    mode_pma <= 1;
    tx_pma <= 1;
    thr <= 4'hf;
    repeat (4) @(negedge clk);
    check("pad in pma", pd_oe, 1'b0);
    push(PKT_PMA_RESP, 0, 0);
    push(PKT_PMA_INC, 0, 0);
    @(posedge clk);
    obj <= 1;
    wt(PKT_PMA_INC, 2 * SC + 20);
    for (int i = 0; i < 7; i++)
    begin
      push(pe[i], 0, 0);
      @(posedge clk);
      thr <= tv[i];
      wt(pe[i], SC + 30);
    end
    push(PKT_PMA_EOC, EPT_OVERTEMP, 1);
    @(posedge clk);
    cond <= 5'h10;
    wt(PKT_PMA_EOC, SC + 30);
    gap("pma");
    check("queue empty", exp_q.size(), 0);
    stop_test();
  end
endmodule : wireless_rx_power_control_tb
